/* dsmtc_pkg.sv */
package dsmtc_pkg;

  // ==========================================================
  // register offsets (address byte)
  localparam logic [7:0] ADDR_GEN_RESET   = 8'h01;
  localparam logic [7:0] ADDR_OUT_GAIN    = 8'hb0;
  localparam logic [7:0] ADDR_IN_ROUTE    = 8'hb1;
  localparam logic [7:0] ADDR_POWERDOWN   = 8'hc0;
  localparam logic [7:0] ADDR_MODE        = 8'hc1;
  localparam logic [7:0] ADDR_AUDIO_PATH  = 8'hc2;
  localparam logic [7:0] ADDR_TX_TONE     = 8'hc3;
  localparam logic [7:0] ADDR_PROG        = 8'hc8;
  localparam logic [7:0] ADDR_TONE_STATUS = 8'hcc;
  localparam logic [7:0] ADDR_AUDIO_CTRL  = 8'hcd;

  // ==========================================================
  // field positions
  localparam int MODE_RX_BIT      = 0;
  localparam int MODE_DTMF_DET    = 1;
  localparam int MODE_SEL_DET     = 2;
  localparam int MODE_TX_BIT      = 7;
  localparam int PATH_RX_INV      = 0;
  localparam int PATH_TX_INV      = 1;
  localparam int PATH_RX_HPF      = 2;
  localparam int PATH_RX_LPF      = 3;
  localparam int PATH_TX_HPF      = 4;
  localparam int ROUTE_RX_SRC_LSB = 0;
  localparam int ROUTE_TX_SRC_LSB = 2;
  localparam int ROUTE_TX_GN_LSB  = 8;
  localparam int ROUTE_RX_GN_LSB  = 12;
  localparam int TONE_SEL_LSB     = 11;
  localparam int TONE_SEL_EN      = 15;
  localparam int TONE_DTMF_LSB    = 0;
  localparam int TONE_SINGLE      = 4;
  localparam int TONE_TWIST       = 5;
  localparam int TONE_DTMF_EN     = 6;
  localparam int AGC_ENABLE_BIT   = 0;
  localparam int AGC_RATE_LSB     = 4;

  // ==========================================================
  // sub-commands in the top nibble
  localparam logic [3:0] ACTL_LEVEL   = 4'hb;
  localparam logic [3:0] ACTL_INVFREQ = 4'hd;
  localparam logic [3:0] PROG_TONEPTR = 4'h1;
  localparam logic [3:0] PROG_TONEFRQ = 4'h2;
  localparam logic [3:0] PROG_AGC     = 4'h4;

  // ==========================================================
  // reset values and limits
  localparam logic [11:0] INV_FREQ_RST  = 12'he74;
  localparam logic [11:0] TONE_MIN_HZ   = 12'h120;
  localparam logic [11:0] TONE_MAX_HZ   = 12'hbb8;
  localparam logic [2:0]  RX_GAIN_RST   = 3'h0;
  localparam logic [2:0]  GAIN_MAX      = 3'h7;
  localparam logic [15:0] REG16_RST     = 16'h0000;
  localparam logic [11:0] CCIR_TABLE [16] = '{
    12'h7bd, 12'h464, 12'h4ad, 12'h4fb, 12'h54e, 12'h5a6, 12'h604, 12'h668,
    12'h6d3, 12'h744, 12'h960, 12'h3a2, 12'h8c7, 12'h3df, 12'h83e, 12'h41f};

  // ==========================================================
  // timing
  localparam int CLK_MHZ         = 250;
  localparam int AGC_TICK_US     = 1000;
  localparam int AGC_TICK_CYCLES = AGC_TICK_US * CLK_MHZ;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] data;
  } dsmtc_wr_s;

  typedef struct packed {
    logic rx_invert;
    logic tx_invert;
    logic rx_hpf;
    logic rx_lpf;
    logic tx_hpf;
  } dsmtc_path_s;

endpackage

/* dsmtc_serial.sv */
`timescale 1ns/1ps
module dsmtc_serial (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  // serial pins
  input  wire logic             i_csn,
  input  wire logic             i_sclk,
  input  wire logic             i_cdata,
  output logic                  o_rdata,
  output logic                  o_rdata_oe_n,
  // register side
  input  wire logic [15:0]      i_rd_data,
  output dsmtc_pkg::dsmtc_wr_s  o_wr,
  output logic                  o_wr_valid,
  output logic                  o_gen_reset
);
  import dsmtc_pkg::*;

  logic [2:0]  csn_q;
  logic [2:0]  sclk_q;
  logic [1:0]  cdata_q;
  logic [4:0]  bit_cnt_q;
  logic [23:0] sr_q;
  logic [15:0] rsr_q;
  logic        reading_q;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_rise;
  logic        cs_low;

  // ==========================================================
  // pin synchronisers; edges only from the second stage onward
  always_ff @(posedge i_clk) begin
    csn_q   <= {csn_q[1:0], i_csn};
    sclk_q  <= {sclk_q[1:0], i_sclk};
    cdata_q <= {cdata_q[0], i_cdata};
  end

  assign cs_low    = ~csn_q[1];
  assign cs_rise   = csn_q[1] & ~csn_q[2];
  assign sclk_rise = cs_low & sclk_q[1] & ~sclk_q[2];
  assign sclk_fall = cs_low & ~sclk_q[1] & sclk_q[2];

  // ==========================================================
  // shift in, msb first
  always_ff @(posedge i_clk) begin
    if (i_reset || !cs_low) begin
      bit_cnt_q <= 5'h00;
      if (i_reset) sr_q <= 24'h000000;
    end else if (sclk_rise && bit_cnt_q != 5'h18) begin
      sr_q      <= {sr_q[22:0], cdata_q[1]};
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // ==========================================================
  // read reply: loaded after the address byte, moved on falling sclk
  always_ff @(posedge i_clk) begin
    if (i_reset || !cs_low) begin
      reading_q    <= 1'b0;
      rsr_q        <= 16'h0000;
      o_rdata      <= 1'b0;
      o_rdata_oe_n <= 1'b1;
    end else if (sclk_rise && bit_cnt_q == 5'h07 &&
                 {sr_q[6:0], cdata_q[1]} == ADDR_TONE_STATUS) begin
      reading_q <= 1'b1;
      rsr_q     <= i_rd_data;
    end else if (sclk_fall && reading_q) begin
      o_rdata      <= rsr_q[15];
      o_rdata_oe_n <= 1'b0;
      rsr_q        <= {rsr_q[14:0], 1'b0};
    end
  end

  // ==========================================================
  // commands take effect at the end of the frame only
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_wr        <= '0;
      o_wr_valid  <= 1'b0;
      o_gen_reset <= 1'b0;
    end else begin
      o_wr_valid  <= cs_rise && bit_cnt_q == 5'h18;
      o_gen_reset <= cs_rise && bit_cnt_q == 5'h08 &&
                     sr_q[7:0] == ADDR_GEN_RESET;
      if (cs_rise) begin
        o_wr <= '{addr: sr_q[23:16], data: sr_q[15:0]};
      end
    end
  end

endmodule

/* dsmtc_top.sv */
`timescale 1ns/1ps
// Behaviour
// - reset or general reset gives idle mode with every section powered down.
// - programming register writes are accepted only while idle.
// - clearing both receive and transmit enables returns the device to idle.
// - receive and transmit enables act independently for half or full duplex.
// - rx path input one to output one, tx two to two; three sources.
// - rx inversion optional, frequency 3700 Hz after reset, changed by D subcommand.
// - rx and tx inversion stages share one programmable inversion point.
// - rx offers separately selectable 300 Hz high-pass and 3.4 kHz low-pass.
// - tx 300 Hz high-pass, when on, attenuates below 250 Hz over 33 dB.
// - rx programmable gain defaults to 0 dB.
// - agc captures input-two gain on tx entry, lowers 3.2 dB steps when high.
// - agc raises gain 3.2 dB steps at programmed rate back to captured gain.
// - ccir selcall table by default, host may load tones 288 to 3000 Hz.
// - dtmf and selcall detectors may be enabled together in receive.
// - tx voice path is disabled while either tone generator runs.
// - selcall tone number bits 14 to 11, dtmf code bits 3 to 0.
// - generated tone level comes from the B subcommand of audio control.
// - tx tone register selects single-tone dtmf and 2 dB twist.
// - writes act within 250 us; host waits before rewriting same register.
// - each write acts at the rising edge of chip select.
// - mode bit 7 enables transmit, bit 0 receive; enable pins follow.
module dsmtc_top #(
  parameter int AGC_TICK = dsmtc_pkg::AGC_TICK_CYCLES
) (
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_reset,
  // serial control pins
  input  wire logic                i_csn,
  input  wire logic                i_sclk,
  input  wire logic                i_cdata,
  output logic                     o_rdata,
  output logic                     o_rdata_oe_n,
  // level and detector inputs
  input  wire logic                i_agc_over,
  input  wire logic                i_agc_under,
  input  wire logic [15:0]         i_tone_status,
  // mode and enable pins
  output logic                     o_idle,
  output logic                     o_rx_en,
  output logic                     o_tx_en,
  output logic                     o_receive_active_output_n,
  output logic                     o_transmit_active_output_n,
  output logic                     o_dtmf_det_en,
  output logic                     o_selcall_det_en,
  // analogue setup
  output logic [15:0]              o_powerdown,
  output logic [15:0]              o_output_gain,
  output logic [1:0]               o_rx_input_channel_src,
  output logic [1:0]               o_tx_input_channel_src,
  output logic [2:0]               o_rx_gain,
  output logic [2:0]               o_tx_gain,
  // voice path
  output dsmtc_pkg::dsmtc_path_s   o_path,
  output logic [11:0]              o_inv_freq,
  output logic                     o_tx_voice_en,
  // tone generator
  output logic                     o_selcall_gen_en,
  output logic                     o_dtmf_gen_en,
  output logic [11:0]              o_selcall_freq,
  output logic [3:0]               o_dtmf_code,
  output logic                     o_dtmf_single,
  output logic                     o_dtmf_twist,
  output logic [11:0]              o_tone_level,
  // programming words passed on
  output logic                     o_prog_valid,
  output logic [15:0]              o_prog_data
);
  import dsmtc_pkg::*;

  typedef enum logic {
    DSMTC_IDLE,
    DSMTC_ACTIVE
  } dsmtc_mode_e;

  dsmtc_wr_s   wr;
  logic        wr_valid;
  logic        gen_reset;
  logic        clr;
  dsmtc_mode_e mode_q;
  logic [15:0] mode_reg_q;
  logic [15:0] route_q;
  logic [15:0] tone_reg_q;
  logic [11:0] table_q [16];
  logic [3:0]  tone_ptr_q;
  logic [11:0] agc_word_q;
  logic [2:0]  agc_init_q;
  logic [2:0]  gain_q;
  logic        tx_prev_q;
  logic [31:0] tick_cnt_q;
  logic [3:0]  rel_cnt_q;
  logic        tick;
  logic        rx_on;
  logic        tx_on;
  logic        prog_ok;

  // ==========================================================
  // serial front end
  dsmtc_serial u_serial (
    .i_clk        (i_clk),
    .i_reset      (i_reset),
    .i_csn        (i_csn),
    .i_sclk       (i_sclk),
    .i_cdata      (i_cdata),
    .o_rdata      (o_rdata),
    .o_rdata_oe_n (o_rdata_oe_n),
    .i_rd_data    (i_tone_status),
    .o_wr         (wr),
    .o_wr_valid   (wr_valid),
    .o_gen_reset  (gen_reset)
  );

  // general reset clears the same state as the pin reset, except inside u_serial, which takes the pin reset only
  assign clr = i_reset | gen_reset;

  function automatic logic is_wr(input logic [7:0] a, input logic v, input dsmtc_wr_s w);
    is_wr = v && w.addr == a;
  endfunction

  function automatic logic tone_in_range(input logic [11:0] f);
    tone_in_range = f >= TONE_MIN_HZ && f <= TONE_MAX_HZ;
  endfunction

  assign rx_on   = mode_reg_q[MODE_RX_BIT];
  assign tx_on   = mode_reg_q[MODE_TX_BIT];
  assign prog_ok = is_wr(ADDR_PROG, wr_valid, wr) && mode_q == DSMTC_IDLE;

  // ==========================================================
  // mode register and idle/active state
  // register writes are applied on the fourth clock edge after chip select rises,
  // well inside the allowed latency
  always_ff @(posedge i_clk) begin
    if (clr) begin
      mode_reg_q <= REG16_RST;
    end else if (is_wr(ADDR_MODE, wr_valid, wr)) begin
      mode_reg_q <= wr.data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (clr) begin
      mode_q <= DSMTC_IDLE;
    end else begin
      case (mode_q)
        DSMTC_IDLE: begin
          if (rx_on || tx_on) mode_q <= DSMTC_ACTIVE;
        end
        DSMTC_ACTIVE: begin
          if (!rx_on && !tx_on) mode_q <= DSMTC_IDLE;
        end
        default: mode_q <= DSMTC_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (clr) begin
      o_idle                     <= 1'b1;
      o_rx_en                    <= 1'b0;
      o_tx_en                    <= 1'b0;
      o_receive_active_output_n  <= 1'b1;
      o_transmit_active_output_n <= 1'b1;
      o_dtmf_det_en              <= 1'b0;
      o_selcall_det_en           <= 1'b0;
    end else begin
      o_idle  <= mode_q == DSMTC_IDLE;
      o_rx_en <= rx_on;
      o_tx_en <= tx_on;
      // pins go low only when exactly one direction is on
      o_receive_active_output_n  <= ~(rx_on & ~tx_on);
      o_transmit_active_output_n <= ~(tx_on & ~rx_on);
      // both detectors may run together; false detects are the host's risk
      o_dtmf_det_en    <= rx_on & mode_reg_q[MODE_DTMF_DET];
      o_selcall_det_en <= rx_on & mode_reg_q[MODE_SEL_DET];
    end
  end

  // ==========================================================
  // analogue setup registers
  always_ff @(posedge i_clk) begin
    if (clr) begin
      o_powerdown   <= REG16_RST;
      o_output_gain <= REG16_RST;
      route_q       <= {1'b0, RX_GAIN_RST, 12'h000};
    end else begin
      if (is_wr(ADDR_POWERDOWN, wr_valid, wr)) o_powerdown <= wr.data;
      if (is_wr(ADDR_OUT_GAIN, wr_valid, wr)) o_output_gain <= wr.data;
      if (is_wr(ADDR_IN_ROUTE, wr_valid, wr)) route_q <= wr.data;
    end
  end

  // outputs are fixed: rx source feeds output one, tx source output two
  always_ff @(posedge i_clk) begin
    if (clr) begin
      o_rx_input_channel_src <= 2'h0;
      o_tx_input_channel_src <= 2'h0;
      o_rx_gain              <= RX_GAIN_RST;
    end else begin
      o_rx_input_channel_src <= route_q[ROUTE_RX_SRC_LSB +: 2];
      o_tx_input_channel_src <= route_q[ROUTE_TX_SRC_LSB +: 2];
      o_rx_gain              <= route_q[ROUTE_RX_GN_LSB +: 3];
    end
  end

  // ==========================================================
  // voice path filters and inversion
  always_ff @(posedge i_clk) begin
    if (clr) begin
      o_path <= '0;
    end else if (is_wr(ADDR_AUDIO_PATH, wr_valid, wr)) begin
      o_path.rx_invert <= wr.data[PATH_RX_INV];
      o_path.tx_invert <= wr.data[PATH_TX_INV];
      o_path.rx_hpf    <= wr.data[PATH_RX_HPF];
      o_path.rx_lpf    <= wr.data[PATH_RX_LPF];
      // analogue filter itself meets the 250 Hz stop-band figure
      o_path.tx_hpf    <= wr.data[PATH_TX_HPF];
    end
  end

  // one inversion point serves both directions
  always_ff @(posedge i_clk) begin
    if (clr) begin
      o_inv_freq   <= INV_FREQ_RST;
      o_tone_level <= 12'h000;
    end else if (is_wr(ADDR_AUDIO_CTRL, wr_valid, wr)) begin
      if (wr.data[15:12] == ACTL_INVFREQ) o_inv_freq <= wr.data[11:0];
      if (wr.data[15:12] == ACTL_LEVEL) o_tone_level <= wr.data[11:0];
    end
  end

  // ==========================================================
  // programming port: tone table and agc word
  always_ff @(posedge i_clk) begin
    if (clr) begin
      o_prog_valid <= 1'b0;
      o_prog_data  <= REG16_RST;
    end else begin
      o_prog_valid <= prog_ok;
      if (prog_ok) o_prog_data <= wr.data;
    end
  end

  // out-of-range tones are dropped, pointer still moves on
  always_ff @(posedge i_clk) begin
    if (clr) begin
      tone_ptr_q <= 4'h0;
      for (int i = 0; i < 16; i++) begin
        table_q[i] <= CCIR_TABLE[i];
      end
    end else if (prog_ok) begin
      if (wr.data[15:12] == PROG_TONEPTR) begin
        tone_ptr_q <= wr.data[3:0];
      end else if (wr.data[15:12] == PROG_TONEFRQ) begin
        if (tone_in_range(wr.data[11:0])) table_q[tone_ptr_q] <= wr.data[11:0];
        tone_ptr_q <= tone_ptr_q + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (clr) begin
      agc_word_q <= 12'h000;
    end else if (prog_ok && wr.data[15:12] == PROG_AGC) begin
      agc_word_q <= wr.data[11:0];
    end
  end

  // ==========================================================
  // tx tone register and generator enables
  always_ff @(posedge i_clk) begin
    if (clr) begin
      tone_reg_q <= REG16_RST;
    end else if (is_wr(ADDR_TX_TONE, wr_valid, wr)) begin
      tone_reg_q <= wr.data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (clr) begin
      o_selcall_gen_en <= 1'b0;
      o_dtmf_gen_en    <= 1'b0;
      o_selcall_freq   <= CCIR_TABLE[0];
      o_dtmf_code      <= 4'h0;
      o_dtmf_single    <= 1'b0;
      o_dtmf_twist     <= 1'b0;
      o_tx_voice_en    <= 1'b0;
    end else begin
      o_selcall_gen_en <= tx_on & tone_reg_q[TONE_SEL_EN];
      o_dtmf_gen_en    <= tx_on & tone_reg_q[TONE_DTMF_EN];
      o_selcall_freq   <= table_q[tone_reg_q[TONE_SEL_LSB +: 4]];
      o_dtmf_code      <= tone_reg_q[TONE_DTMF_LSB +: 4];
      o_dtmf_single    <= tone_reg_q[TONE_SINGLE];
      // twist drops the low tone by 2 dB in the generator
      o_dtmf_twist     <= tone_reg_q[TONE_TWIST];
      // voice muted so only the tone occupies the band
      o_tx_voice_en    <= tx_on & ~tone_reg_q[TONE_SEL_EN]
                          & ~tone_reg_q[TONE_DTMF_EN];
    end
  end

  // ==========================================================
  // tx input agc
  assign tick = tick_cnt_q == 32'(AGC_TICK - 1);

  always_ff @(posedge i_clk) begin
    if (clr || tick) begin
      tick_cnt_q <= 32'h00000000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h00000001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (clr) begin
      tx_prev_q <= 1'b0;
    end else begin
      tx_prev_q <= tx_on;
    end
  end

  // gain written by the host is reloaded at each tx entry
  always_ff @(posedge i_clk) begin
    if (clr) begin
      agc_init_q <= 3'h0;
      gain_q     <= 3'h0;
      rel_cnt_q  <= 4'h0;
    end else if (is_wr(ADDR_IN_ROUTE, wr_valid, wr)) begin
      gain_q <= wr.data[ROUTE_TX_GN_LSB +: 3];
    end else if (tx_on && !tx_prev_q) begin
      agc_init_q <= route_q[ROUTE_TX_GN_LSB +: 3];
      gain_q     <= route_q[ROUTE_TX_GN_LSB +: 3];
      rel_cnt_q  <= 4'h0;
    end else if (tx_on && agc_word_q[AGC_ENABLE_BIT] && tick) begin
      if (i_agc_over) begin
        rel_cnt_q <= 4'h0;
        if (gain_q != 3'h0) gain_q <= gain_q - 3'h1;
      end else if (i_agc_under && gain_q < agc_init_q) begin
        // release is slower than attack by the programmed rate
        if (rel_cnt_q >= agc_word_q[AGC_RATE_LSB +: 4]) begin
          rel_cnt_q <= 4'h0;
          if (gain_q != GAIN_MAX) gain_q <= gain_q + 3'h1;
        end else begin
          rel_cnt_q <= rel_cnt_q + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (clr) begin
      o_tx_gain <= 3'h0;
    end else begin
      o_tx_gain <= gain_q;
    end
  end

endmodule

/* dsmtc_top_asserts.sv */
`timescale 1ns/1ps
module dsmtc_top_asserts #(
  parameter int AGC_TICK = 8
) (
  // clock, reset, pin
  input wire logic                  i_clk,
  input wire logic                  i_reset,
  input wire logic                  i_csn,
  // watched outputs
  input wire logic                  o_idle,
  input wire logic                  o_rx_en,
  input wire logic                  o_tx_en,
  input wire logic                  o_receive_active_output_n,
  input wire logic                  o_transmit_active_output_n,
  input wire logic                  o_dtmf_det_en,
  input wire logic                  o_selcall_det_en,
  input wire logic [15:0]           o_powerdown,
  input wire logic [11:0]           o_inv_freq,
  input wire dsmtc_pkg::dsmtc_path_s o_path,
  input wire logic                  o_tx_voice_en,
  input wire logic                  o_selcall_gen_en,
  input wire logic                  o_dtmf_gen_en,
  input wire logic                  o_prog_valid
);
  import dsmtc_pkg::*;
  // ==========
  // properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  property p_rst;
    $fell(i_reset) |-> o_idle && !o_rx_en && !o_tx_en && o_powerdown == REG16_RST
      && o_inv_freq == INV_FREQ_RST;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  // idle flag trails the enables by one cycle; a general reset clears all at once
  property p_idle;
    o_idle == !($past(o_rx_en) || $past(o_tx_en)) || (o_idle && !o_rx_en && !o_tx_en);
  endproperty
  a_idle: assert property (p_idle) else $error("idle flag wrong");
  property p_rxpin; o_receive_active_output_n == !(o_rx_en && !o_tx_en); endproperty
  a_rxpin: assert property (p_rxpin) else $error("rx pin wrong");
  property p_txpin; o_transmit_active_output_n == !(o_tx_en && !o_rx_en); endproperty
  a_txpin: assert property (p_txpin) else $error("tx pin wrong");
  property p_voice;
    o_tx_voice_en == (o_tx_en && !o_selcall_gen_en && !o_dtmf_gen_en);
  endproperty
  a_voice: assert property (p_voice) else $error("voice gate wrong");
  property p_gen; (o_selcall_gen_en || o_dtmf_gen_en) |-> o_tx_en; endproperty
  a_gen: assert property (p_gen) else $error("tone without tx");
  property p_det; (o_dtmf_det_en || o_selcall_det_en) |-> o_rx_en; endproperty
  a_det: assert property (p_det) else $error("detector without rx");
  property p_prog; o_prog_valid |-> o_idle ##1 !o_prog_valid; endproperty
  a_prog: assert property (p_prog) else $error("prog pulse wrong");
  // frame still open: nothing may have been applied yet
  property p_hold;
    (!i_csn) [*8] |-> $stable(o_path) && $stable(o_inv_freq) && $stable(o_idle);
  endproperty
  a_hold: assert property (p_hold) else $error("change inside frame");
endmodule

/* dsmtc_host.sv */
`timescale 1ns/1ps
module dsmtc_host (
  // clock
  input wire logic i_clk,
  // serial pins
  output logic     o_csn,
  output logic     o_sclk,
  output logic     o_cdata,
  input wire logic i_rdata,
  input wire logic i_rdata_oe_n
);
  // ==========
  // frame task
  initial begin
    o_csn = 1'b1;
    o_sclk = 1'b0;
    o_cdata = 1'b0;
  end
  // sclk parked low between frames; cdata toggled so a stale bit never matches
  task automatic xfer(input logic [23:0] w, input int n, output logic [15:0] rd);
    rd = 16'h0000;
    @(negedge i_clk) o_csn = 1'b0;
    repeat (6) @(negedge i_clk);
    for (int i = 0; i < n; i++) begin
      o_cdata = w[23-i];
      repeat (3) @(negedge i_clk);
      o_sclk = 1'b1;
      repeat (5) @(negedge i_clk);
      if (i >= 8) rd = {rd[14:0], i_rdata_oe_n ? 1'bx : i_rdata};
      o_sclk = 1'b0;
      repeat (3) @(negedge i_clk);
    end
    o_cdata = ~o_cdata;
    o_csn = 1'b1;
    repeat (14) @(negedge i_clk);
  endtask
endmodule

/* tb_dsmtc_top.sv */
`timescale 1ns/1ps
module tb_dsmtc_top;
  import dsmtc_pkg::*;
  localparam int AGC_TICK = 8;
  localparam logic [7:0] MD [4] = '{8'h01, 8'h80, 8'h81, 8'h00};
  localparam logic [4:0] EX [4] = '{5'h09, 5'h06, 5'h0f, 5'h13};
  localparam logic [3:0] TN [5] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'hb};
  localparam logic [11:0] TF [5] = '{12'h200, 12'h54e, 12'hbb8, 12'h300, 12'h3a2};
  logic i_clk = 1'b0, i_reset = 1'b1, i_agc_over = 1'b0, i_agc_under = 1'b0;
  logic i_csn, i_sclk, i_cdata, o_rdata, o_rdata_oe_n, o_idle, o_rx_en, o_tx_en;
  logic o_receive_active_output_n, o_transmit_active_output_n, o_dtmf_det_en;
  logic o_selcall_det_en, o_tx_voice_en, o_selcall_gen_en, o_dtmf_gen_en;
  logic o_dtmf_single, o_dtmf_twist, o_prog_valid;
  logic [15:0] i_tone_status = 16'h0000, o_powerdown, o_output_gain, o_prog_data, r;
  logic [1:0]  o_rx_input_channel_src, o_tx_input_channel_src;
  logic [2:0]  o_rx_gain, o_tx_gain;
  logic [11:0] o_inv_freq, o_selcall_freq, o_tone_level;
  logic [3:0]  o_dtmf_code;
  dsmtc_path_s o_path;
  int          n_mismatch = 0, total_checks = 0;
  wire [4:0] mode_pins = {o_idle, o_rx_en, o_tx_en, o_receive_active_output_n,
                          o_transmit_active_output_n};
  wire [2:0] gen_pins = {o_selcall_gen_en, o_dtmf_gen_en, o_tx_voice_en};
  always #2 i_clk = ~i_clk;
  dsmtc_top #(.AGC_TICK(AGC_TICK)) u_dsmtc_top (.i_clk, .i_reset, .i_csn, .i_sclk,
    .i_cdata, .o_rdata, .o_rdata_oe_n, .i_agc_over, .i_agc_under, .i_tone_status,
    .o_idle, .o_rx_en, .o_tx_en, .o_receive_active_output_n, .o_transmit_active_output_n,
    .o_dtmf_det_en, .o_selcall_det_en, .o_powerdown, .o_output_gain,
    .o_rx_input_channel_src, .o_tx_input_channel_src, .o_rx_gain, .o_tx_gain, .o_path,
    .o_inv_freq, .o_tx_voice_en, .o_selcall_gen_en, .o_dtmf_gen_en, .o_selcall_freq,
    .o_dtmf_code, .o_dtmf_single, .o_dtmf_twist, .o_tone_level, .o_prog_valid,
    .o_prog_data);
  dsmtc_host u_dsmtc_host (.i_clk(i_clk), .o_csn(i_csn), .o_sclk(i_sclk),
    .o_cdata(i_cdata), .i_rdata(o_rdata), .i_rdata_oe_n(o_rdata_oe_n));
  // ==========
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] rd;
    u_dsmtc_host.xfer({a, d}, 24, rd);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_gain(input logic [2:0] e);
    int k;
    for (k = 0; k < 400 && o_tx_gain !== e; k++) @(negedge i_clk);
    total_checks++;
    if (k == 400) begin
      n_mismatch++;
      $display("BAD %0t agc gain stuck", $time);
      summarize();
    end
  endtask
  // ==========
  // sequence
  initial begin
    repeat (2) @(negedge i_clk);
    i_reset = 1'b0;
    @(negedge i_clk);
    chk({11'h0, mode_pins}, 16'h0013);
    chk(o_powerdown, REG16_RST);
    chk({4'h0, o_inv_freq}, {4'h0, INV_FREQ_RST});
    chk({13'h0, o_rx_gain}, {13'h0, RX_GAIN_RST});
    $display("test reset done");
    wr(ADDR_PROG, {PROG_TONEPTR, 12'h003});
    wr(ADDR_PROG, {PROG_TONEFRQ, 12'h200});
    wr(ADDR_PROG, {PROG_TONEFRQ, 12'h050});
    wr(ADDR_PROG, {PROG_TONEFRQ, TONE_MAX_HZ});
    wr(ADDR_PROG, {PROG_AGC, 12'h001});
    chk(o_prog_data, {PROG_AGC, 12'h001});
    wr(ADDR_POWERDOWN, 16'h00ff);
    wr(ADDR_OUT_GAIN, 16'h1234);
    wr(ADDR_IN_ROUTE, 16'h0509);
    chk(o_powerdown, 16'h00ff);
    chk(o_output_gain, 16'h1234);
    chk({12'h0, o_tx_input_channel_src, o_rx_input_channel_src}, 16'h0009);
    chk({10'h0, o_rx_gain, o_tx_gain}, 16'h0005);
    $display("test setup done");
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_MODE, {8'h00, MD[i]});
      chk({11'h0, mode_pins}, {11'h0, EX[i]});
    end
    wr(ADDR_MODE, 16'h0007);
    chk({14'h0, o_dtmf_det_en, o_selcall_det_en}, 16'h0003);
    wr(ADDR_PROG, {PROG_TONEPTR, 12'h009});
    wr(ADDR_MODE, 16'h0000);
    wr(ADDR_PROG, {PROG_TONEFRQ, 12'h300});
    $display("test modes done");
    wr(ADDR_IN_ROUTE, 16'h0309);
    wr(ADDR_MODE, 16'h0080);
    i_agc_over = 1'b1;
    for (int g = 2; g >= 0; g--) wait_gain(g[2:0]);
    i_agc_over = 1'b0;
    i_agc_under = 1'b1;
    wait_gain(3'h3);
    repeat (40) @(negedge i_clk);
    chk({13'h0, o_tx_gain}, 16'h0003);
    i_agc_under = 1'b0;
    $display("test agc done");
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_TX_TONE, {1'b1, TN[i], 11'h000});
      chk({4'h0, o_selcall_freq}, {4'h0, TF[i]});
      chk({13'h0, gen_pins}, 16'h0004);
    end
    wr(ADDR_TX_TONE, {1'b1, 4'he, 11'h000});
    chk({4'h0, o_selcall_freq}, {4'h0, CCIR_TABLE[14]});
    wr(ADDR_TX_TONE, 16'h007a);
    chk({10'h0, o_dtmf_single, o_dtmf_twist, o_dtmf_code}, 16'h003a);
    chk({13'h0, gen_pins}, 16'h0002);
    wr(ADDR_TX_TONE, 16'h0000);
    chk({13'h0, gen_pins}, 16'h0001);
    $display("test tones done");
    wr(ADDR_AUDIO_PATH, 16'h0005);
    chk({11'h0, o_path}, 16'h0014);
    wr(ADDR_AUDIO_PATH, 16'h001a);
    chk({11'h0, o_path}, 16'h000b);
    wr(ADDR_AUDIO_CTRL, {ACTL_INVFREQ, 12'h123});
    wr(ADDR_AUDIO_CTRL, {ACTL_LEVEL, 12'h456});
    wr(8'h55, 16'hffff);
    chk({11'h0, o_path}, 16'h000b);
    chk({4'h0, o_inv_freq}, 16'h0123);
    chk({4'h0, o_tone_level}, 16'h0456);
    i_tone_status = 16'hc35a;
    u_dsmtc_host.xfer({ADDR_TONE_STATUS, 16'h0000}, 24, r);
    chk(r, 16'hc35a);
    $display("test path done");
    u_dsmtc_host.xfer({ADDR_GEN_RESET, 16'h0000}, 8, r);
    chk({4'h0, o_inv_freq}, {4'h0, INV_FREQ_RST});
    chk({11'h0, mode_pins}, 16'h0013);
    chk(o_powerdown, REG16_RST);
    $display("test general reset done");
    summarize();
  end
endmodule
bind dsmtc_top dsmtc_top_asserts #(.AGC_TICK(AGC_TICK)) u_dsmtc_top_asserts (.i_clk,
  .i_reset, .i_csn, .o_idle, .o_rx_en, .o_tx_en, .o_receive_active_output_n,
  .o_transmit_active_output_n, .o_dtmf_det_en, .o_selcall_det_en, .o_powerdown,
  .o_inv_freq, .o_path, .o_tx_voice_en, .o_selcall_gen_en, .o_dtmf_gen_en, .o_prog_valid);
